// ==== rtl/dco_top.sv ====
// Top of the dual converter digital output interface.
// Assumes sample clocks and control pins are asynchronous to clock;
// raw converter codes arrive as offset binary on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dco_top
  import dco_pkg::*;
#(
  parameter int WIDTH = DCO_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic chan_a_sample_clock,
  input wire logic chan_b_sample_clock,
  input wire logic bus_swap_select,
  input wire logic chan_a_power_down_select,
  input wire logic chan_b_power_down_select,
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  input wire logic [1:0] format_level,
  input wire logic [WIDTH-1:0] chan_a_sample,
  input wire logic chan_a_out_of_range,
  input wire logic [WIDTH-1:0] chan_b_sample,
  input wire logic chan_b_out_of_range,
  input wire logic capture_ready,
  output logic [WIDTH-1:0] bus_a_data,
  output logic bus_a_oe,
  output logic [WIDTH-1:0] bus_b_data,
  output logic bus_b_oe,
  output logic data_ready_clock,
  output logic range_exceeded_flag,
  output logic word_valid,
  output logic stall,
  output logic stabilizer_on,
  output dco_mode_t chan_a_mode,
  output dco_mode_t chan_b_mode
);
  // Buffer entry layout is fixed at the documented width
  if (WIDTH != DCO_WIDTH) begin : g_bad_width
    $error("dco_top: width must be twelve");
  end
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] s1_ff, s2_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= 7'h00;
      s2_ff <= 7'h00;
    end else begin
      s1_ff <= {chan_a_sample_clock, chan_b_sample_clock, bus_swap_select,
                chan_a_power_down_select, chan_b_power_down_select,
                chan_a_output_enable_n, chan_b_output_enable_n};
      s2_ff <= s1_ff;
    end
  end
  logic [1:0] fmt1_ff, fmt2_ff;             // Format level synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      fmt1_ff <= DCO_FMT_OB_OFF;
      fmt2_ff <= DCO_FMT_OB_OFF;
    end else begin
      fmt1_ff <= format_level;
      fmt2_ff <= fmt1_ff;
    end
  end
  // ----------------------------------------
  // Shared format decode
  // ----------------------------------------
  logic twos_comp;
  always_comb begin
    unique case (fmt2_ff)
      DCO_FMT_OB_OFF: {twos_comp, stabilizer_on} = 2'b00;
      DCO_FMT_OB_ON: {twos_comp, stabilizer_on} = 2'b01;
      DCO_FMT_TC_ON: {twos_comp, stabilizer_on} = 2'b11;
      DCO_FMT_TC_OFF: {twos_comp, stabilizer_on} = 2'b10;
    endcase
  end
  // ----------------------------------------
  // Channels
  // ----------------------------------------
  logic [WIDTH-1:0] wa, wb;
  logic oa, ob, sa, sb, ea, eb;
  dco_channel #(.WIDTH(WIDTH), .LATENCY(DCO_LATENCY)) u_a (
    .clock(clock), .rst(rst), .samp_clk_s(s2_ff[6]),
    .power_down(s2_ff[3]), .output_enable_n(s2_ff[1]),
    .sample_in(chan_a_sample), .sample_ovr(chan_a_out_of_range),
    .twos_comp(twos_comp), .word_out(wa), .word_ovr(oa),
    .word_stb(sa), .drive_en(ea), .mode(chan_a_mode)
  );
  dco_channel #(.WIDTH(WIDTH), .LATENCY(DCO_LATENCY)) u_b (
    .clock(clock), .rst(rst), .samp_clk_s(s2_ff[5]),
    .power_down(s2_ff[2]), .output_enable_n(s2_ff[0]),
    .sample_in(chan_b_sample), .sample_ovr(chan_b_out_of_range),
    .twos_comp(twos_comp), .word_out(wb), .word_ovr(ob),
    .word_stb(sb), .drive_en(eb), .mode(chan_b_mode)
  );
  // ----------------------------------------
  // Two-entry buffer on channel B strobe
  // ----------------------------------------
  // Entry: {ovr, b word, a word}
  localparam int EW = 2 * WIDTH + 1;
  logic [EW-1:0] buf_ff [2];
  logic [EW-1:0] nxt_buf [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;
  // data-ready paced by channel B clock
  always_comb begin
    push = sb && (cnt_ff != 2'h2);
    pop = (cnt_ff != 2'h0) && capture_ready;
    nxt_buf = buf_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_cnt = cnt_ff - 2'h1;
    end
    if (push) begin
      nxt_buf[nxt_cnt[0]] = {oa | ob, wb, wa};
      nxt_cnt = nxt_cnt + 2'h1;
    end
    stall = sb && (cnt_ff == 2'h2);
    word_valid = (cnt_ff != 2'h0);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= 2'h0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      buf_ff <= nxt_buf;
    end
  end
  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [WIDTH-1:0] bus_a_ff, bus_b_ff, nxt_bus_a, nxt_bus_b;
  logic of_ff, nxt_of, drc_ff, nxt_drc;
  always_comb begin
    if (s2_ff[4]) begin
      nxt_bus_a = buf_ff[0][WIDTH-1:0];
      nxt_bus_b = buf_ff[0][2*WIDTH-1:WIDTH];
    end else begin
      nxt_bus_a = buf_ff[0][2*WIDTH-1:WIDTH];
      nxt_bus_b = buf_ff[0][WIDTH-1:0];
    end
    nxt_of = buf_ff[0][EW-1];
    // Clock high one cycle as each word is put out; capture falls on its drop
    nxt_drc = pop;
    // Bus holds until the next word is popped
    if (!pop) begin
      nxt_bus_a = bus_a_ff;
      nxt_bus_b = bus_b_ff;
      nxt_of = of_ff;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_a_ff <= '0;
      bus_b_ff <= '0;
      of_ff <= 1'b0;
      drc_ff <= 1'b0;
    end else begin
      bus_a_ff <= nxt_bus_a;
      bus_b_ff <= nxt_bus_b;
      of_ff <= nxt_of;
      drc_ff <= nxt_drc;
    end
  end
  // Drive enables follow the channel that owns each bus
  always_comb begin
    bus_a_data = bus_a_ff;
    bus_b_data = bus_b_ff;
    bus_a_oe = s2_ff[4] ? ea : eb;
    bus_b_oe = s2_ff[4] ? eb : ea;
    range_exceeded_flag = of_ff;
    data_ready_clock = drc_ff;
  end
endmodule
`default_nettype wire

// ==== rtl/dco_pkg.sv ====
// Constants shared by the dual converter output interface.
// Assumes a 20 MHz system clock and sample clocks sampled as slow inputs.
package dco_pkg;
  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int DCO_WIDTH = 12;
  localparam int DCO_LATENCY = 5;
  localparam int DCO_MSB_POS = 11;
  // ----------------------------------------
  // Channel power modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCO_NORMAL = 2'h0,
    DCO_FLOAT = 2'h1,
    DCO_NAP = 2'h2,
    DCO_SLEEP = 2'h3
  } dco_mode_t;
  // ----------------------------------------
  // Four format levels
  // ----------------------------------------
  localparam logic [1:0] DCO_FMT_OB_OFF = 2'h0;
  localparam logic [1:0] DCO_FMT_OB_ON = 2'h1;
  localparam logic [1:0] DCO_FMT_TC_ON = 2'h2;
  localparam logic [1:0] DCO_FMT_TC_OFF = 2'h3;
endpackage

// ==== rtl/dco_channel.sv ====
// One converter channel: edge detect, five-deep pipeline, mode decode.
// Assumes the sample clock is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none
module dco_channel
  import dco_pkg::*;
#(
  parameter int WIDTH = DCO_WIDTH,
  parameter int LATENCY = DCO_LATENCY
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic samp_clk_s,
  input wire logic power_down,
  input wire logic output_enable_n,
  input wire logic [WIDTH-1:0] sample_in,
  input wire logic sample_ovr,
  input wire logic twos_comp,
  output logic [WIDTH-1:0] word_out,
  output logic word_ovr,
  output logic word_stb,
  output logic drive_en,
  output dco_mode_t mode
);
  // Refuse a pipeline or word the logic cannot serve
  if (LATENCY < 1 || WIDTH < 2) begin : g_bad_params
    $error("dco_channel: bad parameters");
  end
  // ----------------------------------------
  // Pipeline state
  // ----------------------------------------
  logic prev_ff, nxt_prev;                 // Last sampled clock level
  logic [WIDTH:0] pipe_ff [LATENCY];        // Overflow bit plus data
  logic [WIDTH:0] nxt_pipe [LATENCY];
  logic rise;                               // Sample clock rising edge
  // Mode decode from power-down and enable
  always_comb begin
    unique case ({power_down, output_enable_n})
      2'b00: mode = DCO_NORMAL;
      2'b01: mode = DCO_FLOAT;
      2'b10: mode = DCO_NAP;
      2'b11: mode = DCO_SLEEP;
    endcase
    drive_en = (mode == DCO_NORMAL);
  end
  // Next pipeline values
  always_comb begin
    nxt_prev = samp_clk_s;
    rise = samp_clk_s & ~prev_ff & ~power_down;
    for (int i = 0; i < LATENCY; i++) nxt_pipe[i] = pipe_ff[i];
    if (rise) begin
      nxt_pipe[0] = {sample_ovr, sample_in};
      for (int i = 1; i < LATENCY; i++) nxt_pipe[i] = pipe_ff[i-1];
    end
  end
  // Register pipeline
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_ff <= 1'b0;
      for (int i = 0; i < LATENCY; i++) pipe_ff[i] <= '0;
    end else begin
      prev_ff <= nxt_prev;
      pipe_ff <= nxt_pipe;
    end
  end
  // Output word with format applied
  always_comb begin
    // MSB on top bit, inverted for two's complement
    word_out = pipe_ff[LATENCY-1][WIDTH-1:0];
    word_out[WIDTH-1] = pipe_ff[LATENCY-1][WIDTH-1] ^ twos_comp;
    word_ovr = pipe_ff[LATENCY-1][WIDTH];
    word_stb = rise;
  end
endmodule
`default_nettype wire

// ==== tb/dco_top_asserts.sv ====
// Checker for the dual converter output top: mode, enable and buffer relations.
// Assumes the controls are held steady for a few clocks before they are judged.
`timescale 1ns/1ps
`default_nettype none
module dco_top_asserts
  import dco_pkg::*;
#(
  parameter int WIDTH = DCO_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic bus_swap_select,
  input wire logic chan_a_power_down_select,
  input wire logic chan_b_power_down_select,
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  input wire logic [1:0] format_level,
  input wire logic [WIDTH-1:0] bus_a_data,
  input wire logic bus_a_oe,
  input wire logic bus_b_oe,
  input wire logic data_ready_clock,
  input wire logic word_valid,
  input wire logic stall,
  input wire logic stabilizer_on,
  input wire dco_mode_t chan_a_mode,
  input wire dco_mode_t chan_b_mode
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_mode_a;
    $stable({chan_a_power_down_select, chan_a_output_enable_n})[*6] |->
      chan_a_mode == dco_mode_t'({chan_a_power_down_select, chan_a_output_enable_n});
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("channel A mode wrong");
  property p_mode_b;
    $stable({chan_b_power_down_select, chan_b_output_enable_n})[*6] |->
      chan_b_mode == dco_mode_t'({chan_b_power_down_select, chan_b_output_enable_n});
  endproperty
  a_mode_b: assert property (p_mode_b) else $error("channel B mode wrong");
  property p_stab;
    $stable(format_level)[*6] |-> stabilizer_on == (format_level inside {2'h1, 2'h2});
  endproperty
  a_stab: assert property (p_stab) else $error("stabilizer wrong");
  property p_oe_a;
    $stable(bus_swap_select)[*6] |->
      bus_a_oe == (bus_swap_select ? chan_a_mode == DCO_NORMAL : chan_b_mode == DCO_NORMAL);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("bus A enable wrong");
  property p_oe_b;
    $stable(bus_swap_select)[*6] |->
      bus_b_oe == (bus_swap_select ? chan_b_mode == DCO_NORMAL : chan_a_mode == DCO_NORMAL);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("bus B enable wrong");
  property p_stall;
    stall |-> word_valid;
  endproperty
  a_stall: assert property (p_stall) else $error("stall with empty buffer");
  property p_hold;
    (!word_valid && $stable(bus_swap_select))[*4] |=> $stable(bus_a_data);
  endproperty
  a_hold: assert property (p_hold) else $error("bus A changed with no word");
  property p_drc;
    $rose(data_ready_clock) |-> $past(word_valid);
  endproperty
  a_drc: assert property (p_drc) else $error("ready clock without word");
endmodule
bind dco_top dco_top_asserts #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// ==== tb/dco_capture.sv ====
// Capture logic model: latches both buses at the ready clock falling edge.
// Assumes the ready clock is slow enough to be sampled by clock.
`timescale 1ns/1ps
`default_nettype none
module dco_capture
  import dco_pkg::*;
(
  input wire logic clock,
  input wire logic hold,
  input wire logic data_ready_clock,
  input wire logic [DCO_WIDTH-1:0] bus_a_data,
  input wire logic bus_a_oe,
  input wire logic [DCO_WIDTH-1:0] bus_b_data,
  input wire logic bus_b_oe,
  output logic capture_ready,
  output logic [DCO_WIDTH-1:0] got_a,
  output logic [DCO_WIDTH-1:0] got_b
);
  logic drc_q; // Last ready clock level
  // Floated bus shows inverse of last word
  wire logic [DCO_WIDTH-1:0] wire_a = bus_a_oe ? bus_a_data : ~got_a;
  wire logic [DCO_WIDTH-1:0] wire_b = bus_b_oe ? bus_b_data : ~got_b;
  assign capture_ready = !hold;
  always @(posedge clock) begin
    drc_q <= data_ready_clock;
    if (drc_q && !data_ready_clock) begin
      got_a <= wire_a;
      got_b <= wire_b;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dco_top_tb.sv ====
// Self-checking bench for the dual converter output top.
// Assumes both sample clocks come from one 400 ns source.
`timescale 1ns/1ps
`default_nettype none
module dco_top_tb;
  import dco_pkg::*;
  logic clock, rst, swap, pd_a, pd_b, oen_a, oen_b, ovr_a, ovr_b, hold;
  logic sclk = 1'b0; // Shared sample clock
  logic seen = 1'b0; // Stall observed
  logic [1:0] fmt;
  logic [11:0] smp_a, smp_b, bus_a, bus_b, got_a, got_b;
  logic oe_a, oe_b, drc, flag, valid, stall, stab, rdy;
  dco_mode_t mode_a, mode_b;
  logic [2:0] ph = 3'h0; // Sample clock phase
  int failures, tests_run;
  // one clock for both; swap kept a level, not interleaved
  dco_top u_dut (.clock(clock), .rst(rst), .chan_a_sample_clock(sclk), .chan_b_sample_clock(sclk),
    .bus_swap_select(swap), .chan_a_power_down_select(pd_a), .chan_b_power_down_select(pd_b),
    .chan_a_output_enable_n(oen_a), .chan_b_output_enable_n(oen_b), .format_level(fmt),
    .chan_a_sample(smp_a), .chan_a_out_of_range(ovr_a), .chan_b_sample(smp_b), .chan_b_out_of_range(ovr_b),
    .capture_ready(rdy), .bus_a_data(bus_a), .bus_a_oe(oe_a), .bus_b_data(bus_b), .bus_b_oe(oe_b),
    .data_ready_clock(drc), .range_exceeded_flag(flag), .word_valid(valid), .stall(stall),
    .stabilizer_on(stab), .chan_a_mode(mode_a), .chan_b_mode(mode_b));
  dco_capture u_cap (.clock(clock), .hold(hold), .data_ready_clock(drc), .bus_a_data(bus_a), .bus_a_oe(oe_a),
    .bus_b_data(bus_b), .bus_b_oe(oe_b), .capture_ready(rdy), .got_a(got_a), .got_b(got_b));
  // Clock and 400 ns sample clock
  always #25 clock = ~clock;
  always @(posedge clock) begin
    ph <= ph + 3'h1;
    sclk <= (ph < 3'h3);
    if (stall === 1'b1) seen <= 1'b1;
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] fmt_word(input logic [11:0] v, input logic [1:0] l);
    return (l >= 2'h2) ? (v ^ 12'h800) : v;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200us;
    failures++;
    conclude();
  end
  initial begin
    logic [11:0] a, b;
    logic [1:0] o;
    {clock, swap, pd_a, pd_b, oen_a, oen_b, ovr_a, ovr_b, hold, fmt} = '0;
    {smp_a, smp_b, failures, tests_run} = '0;
    rst = 1'b1;
    void'($urandom(28));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Both bus orders, every format level
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 12'hfff : 12'($urandom);
      b = (i == 0) ? 12'h000 : 12'($urandom);
      o = 2'($urandom);
      @(posedge clock);
      {swap, fmt, smp_a, smp_b, ovr_a, ovr_b} <= {i[2], i[1:0], a, b, o};
      repeat (64) @(posedge clock);
      check(got_a, fmt_word(i[2] ? a : b, i[1:0]));
      check(got_b, fmt_word(i[2] ? b : a, i[1:0]));
      check({10'h0, stab, flag}, {10'h0, i[1] ^ i[0], o[1] | o[0]});
      $display("format and swap test %0d done", i);
    end
    // Power modes, B set to the inverse of A
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      {pd_a, oen_a, pd_b, oen_b} <= {m[1:0], ~m[1:0]};
      repeat (16) @(posedge clock);
      check({8'h0, mode_a, mode_b}, {8'h0, m[1:0], ~m[1:0]});
      check({10'h0, oe_a, oe_b}, {10'h0, m == 0, m == 3});
      $display("power mode test %0d done", m);
    end
    // Five-sample pipeline delay
    @(posedge clock);
    {pd_a, oen_a, pd_b, oen_b} <= 4'h0;
    repeat (64) @(posedge clock);
    a = smp_a ^ 12'h5a5;
    @(posedge clock iff ph == 3'h0);
    smp_a <= a;
    repeat (38) @(posedge clock);
    check(got_a, fmt_word(smp_a ^ 12'h5a5, fmt));
    repeat (10) @(posedge clock);
    check(got_a, fmt_word(a, fmt));
    $display("latency test done");
    // Stalled sink fills buffer, then drains
    hold <= 1'b1;
    repeat (40) @(posedge clock);
    check({10'h0, seen, valid}, 12'h003);
    hold <= 1'b0;
    repeat (16) if (valid === 1'b1) @(posedge clock);
    check({11'h0, valid}, 12'h000);
    $display("buffer test done");
    conclude();
  end
endmodule
`default_nettype wire
